/* bench/ppc_i2c_host.sv */
// i2c host model that drives the serial clock and host side of data
`timescale 1ns/100ps
module ppc_i2c_host (
  input wire logic sda_wire,
  output logic scl,
  output logic sda_m,
  output logic [7:0] rd_byte,
  output logic rd_valid
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
    rd_byte = 8'h00;
    rd_valid = 1'b0;
  end
  // clock idles high between frames; data moves mid-low, sampled late high
  task automatic bit_io(input logic b, output logic s);
    scl = 1'b0;
    #50 sda_m = b;
    #50 scl = 1'b1;
    #100 s = sda_wire;
  endtask
  task automatic start;
    sda_m = 1'b0;
    #100;
  endtask
  task automatic stop;
    scl = 1'b0;
    #50 sda_m = 1'b0;
    #50 scl = 1'b1;
    #50 sda_m = 1'b1;
    #100;
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic write_reg(input logic [6:0] a, input logic [7:0] p,
                           input logic [7:0] d, output logic ok);
    logic k;
    start();
    put_byte({a, 1'b0}, ok);
    put_byte(p, k);
    put_byte(d, k);
    stop();
  endtask
  task automatic read_reg(input logic [6:0] a, input logic [7:0] p);
    logic k;
    logic [7:0] b;
    start();
    put_byte({a, 1'b0}, k);
    put_byte(p, k);
    scl = 1'b0;
    #50 sda_m = 1'b1;
    #50 scl = 1'b1;
    #50 start();
    put_byte({a, 1'b1}, k);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(1'b1, k);
    stop();
    rd_byte = b;
    rd_valid = 1'b1;
    #25 rd_valid = 1'b0;
  endtask
endmodule

/* bench/ppc_port_control_tb.sv */
// self-checking bench of the port control block
`timescale 1ns/100ps
module ppc_port_control_tb;
  localparam int FC = 20;
  localparam logic [7:0] MREG = ppc_pkg::REG_INTERRUPT_MASK;
  localparam logic [7:0] SREG = ppc_pkg::REG_PORT_RESET_STROBE;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic reset_n_pin = 1'b1;
  logic midspan_sel = 1'b0;
  logic standalone_sel = 1'b0;
  logic group_off_n = 1'b1;
  logic clk_en = 1'b1;
  logic [3:0] strap, sense, volt, sig, unplug, off_n;
  wire scl, sda_m, rd_valid;
  wire [7:0] rd_byte;
  logic drv, drv_oe, int_n, int_n_oe, midspan_mode;
  logic [3:0] fet_drive, power_good;
  logic [15:0] exp_q[$];
  logic [15:0] m;
  logic [31:0] lfsr = 32'hf243;
  logic [6:0] dev;
  logic ok;
  int bad_count = 0;
  int checks_done = 0;
  // open-drain data line with pull-up
  wire sda_wire = sda_m & (drv_oe ? drv : 1'b1);
  // interrupt line as seen with its pull-up
  wire int_pin = int_n_oe ? int_n : 1'b1;

  always #12.5 clock = ~clock;

  ppc_port_control #(.FAULT_CYCLES(FC)) ppc_port_control_i (
    .clock(clock), .srst(srst), .clk_en(clk_en),
    .reset_n_pin(reset_n_pin), .midspan_sel(midspan_sel),
    .standalone_sel(standalone_sel),
    .addr_strap_0(strap[0]), .addr_strap_1(strap[1]),
    .addr_strap_2(strap[2]), .addr_strap_3(strap[3]),
    .port_off_n_1(off_n[0]), .port_off_n_2(off_n[1]),
    .port_off_n_3(off_n[2]), .port_off_n_4(off_n[3]),
    .group_off_n(group_off_n), .scl(scl), .serial_data_sense(sda_wire),
    .serial_data_drive(drv), .serial_data_drive_oe(drv_oe),
    .int_n(int_n), .int_n_oe(int_n_oe), .current_sense_in(sense),
    .port_voltage_in(volt), .signature_ok(sig), .unplugged(unplug),
    .fet_drive(fet_drive), .power_good(power_good),
    .midspan_mode(midspan_mode));

  ppc_i2c_host ppc_i2c_host_i (
    .sda_wire(sda_wire), .scl(scl), .sda_m(sda_m),
    .rd_byte(rd_byte), .rd_valid(rd_valid));

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wait_fet(input int p, input logic v);
    for (int i = 0; i < 60 && fet_drive[p] !== v; i++) cyc(1);
    check(8'(fet_drive[p]), 8'(v));
    if (fet_drive[p] !== v) conclude();
  endtask
  // reads note the expected byte with a mask of the bits that matter
  task automatic rd(input logic [7:0] p, input logic [7:0] mk,
                    input logic [7:0] e);
    exp_q.push_back({mk, e});
    ppc_i2c_host_i.read_reg(dev, p);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    ppc_i2c_host_i.write_reg(dev, p, d, ok);
    check(8'(ok), 8'h01);
  endtask
  task automatic power(input int p, input logic v);
    sig[p] = 1'b1;
    volt[p] = v;
    wait_fet(p, 1'b1);
    sig[p] = 1'b0;
    cyc(4);
    check(8'(power_good[p]), 8'(v));
  endtask
  task automatic fault(input int p);
    sense[p] = 1'b1;
    cyc(FC - 4);
    check(8'(fet_drive[p]), 8'h01);
    wait_fet(p, 1'b0);
    sense[p] = 1'b0;
  endtask
  task automatic int_is(input logic v);
    cyc(10);
    check(8'(int_n_oe), 8'(v));
    check(8'(int_pin), 8'(!v));
  endtask

  always @(posedge rd_valid) begin
    m = exp_q.pop_front();
    check(rd_byte & m[15:8], m[7:0]);
  end

  initial begin
    #2_000_000;
    bad_count++;
    conclude();
  end

  initial begin
    strap = lfsr[3:0];
    sense = 4'h0;
    volt = 4'h0;
    sig = 4'h0;
    unplug = 4'h0;
    off_n = 4'hf;
    dev = {ppc_pkg::ADDR_PREFIX, strap};
    cyc(4);
    srst = 1'b0;
    cyc(4);
    check(8'(fet_drive), 8'h00);
    int_is(1'b0);
    rd(MREG, 8'hff, ppc_pkg::MASK_RST_HOST);
    for (int i = 0; i < 7; i++) begin
      ppc_i2c_host_i.write_reg(dev ^ 7'(1 << i), MREG, 8'h00, ok);
      check(8'(ok), 8'h00);
    end
    lfsr = nxt(lfsr);
    wr(MREG, lfsr[7:0]);
    rd(MREG, 8'hff, lfsr[7:0]);
    rd(8'h05, 8'hff, 8'h00);
    standalone_sel = 1'b1;
    midspan_sel = 1'b1;
    cyc(4);
    rd(ppc_pkg::REG_PIN_STATE, 8'h07, 8'h03);
    srst = 1'b1;
    cyc(2);
    srst = 1'b0;
    cyc(4);
    rd(MREG, 8'hff, ppc_pkg::MASK_RST_STANDALONE);
    check(8'(midspan_mode), 8'h01);
    standalone_sel = 1'b0;
    midspan_sel = 1'b0;
    // mask is zero here: a timeout event must stay silent
    power(0, 1'b1);
    fault(0);
    int_is(1'b0);
    rd(ppc_pkg::REG_EVENT_STATUS, 8'hff, 8'h01);
    wr(MREG, 8'h01);
    int_is(1'b1);
    wr(SREG, 8'h40);
    int_is(1'b0);
    power(0, 1'b1);
    ppc_i2c_host_i.start();
    ppc_i2c_host_i.put_byte({dev, 1'b0}, ok);
    check(8'(ok), 8'h01);
    fault(0);
    int_is(1'b0);
    ppc_i2c_host_i.stop();
    int_is(1'b1);
    wr(SREG, 8'h80);
    int_is(1'b0);
    wr(MREG, 8'h10);
    power(0, 1'b0);
    fault(0);
    int_is(1'b1);
    rd(ppc_pkg::REG_EVENT_STATUS, 8'hff, 8'h10);
    wr(SREG, 8'h40);
    power(0, 1'b1);
    off_n[0] = 1'b0;
    cyc(20);
    off_n[0] = 1'b1;
    cyc(50);
    check(8'(fet_drive[0]), 8'h01);
    off_n[0] = 1'b0;
    wait_fet(0, 1'b0);
    off_n[0] = 1'b1;
    wr(ppc_pkg::REG_SHUTDOWN_MASK_CONFIG, 8'h02);
    power(0, 1'b1);
    power(1, 1'b1);
    group_off_n = 1'b0;
    wait_fet(1, 1'b0);
    check(8'(fet_drive[0]), 8'h01);
    group_off_n = 1'b1;
    wr(SREG, 8'h01);
    wait_fet(0, 1'b0);
    power(2, 1'b1);
    // clock enable low freezes the port through an unplug
    clk_en = 1'b0;
    unplug[2] = 1'b1;
    cyc(20);
    check(8'(fet_drive[2]), 8'h01);
    clk_en = 1'b1;
    wait_fet(2, 1'b0);
    unplug[2] = 1'b0;
    wr(MREG, 8'h5a);
    reset_n_pin = 1'b0;
    cyc(20);
    reset_n_pin = 1'b1;
    cyc(10);
    rd(MREG, 8'hff, 8'h5a);
    power(3, 1'b1);
    reset_n_pin = 1'b0;
    wait_fet(3, 1'b0);
    reset_n_pin = 1'b1;
    cyc(10);
    rd(MREG, 8'hff, ppc_pkg::MASK_RST_HOST);
    // reset-all strobe restores the registers too
    wr(MREG, 8'h3c);
    wr(SREG, 8'h10);
    rd(MREG, 8'hff, ppc_pkg::MASK_RST_HOST);
    cyc(10);
    conclude();
  end
endmodule

/* verilog/ppc_pkg.sv */
// shared constants, types and register map of the port control block
package ppc_pkg;
  localparam int NPORT = 4;
  localparam int NFILT = 6;
  localparam int CLK_MHZ = 40;
  // glitch filter interval in ns, least time so rounded up
  localparam int FILT_NS = 1000;
  localparam int FILT_CYCLES = (FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_W = 6;
  // overcurrent fault time in us, longest time so rounded down
  localparam int CUT_US = 62500;
  localparam int CUT_CYCLES = CUT_US * CLK_MHZ;
  localparam int CUT_W = 22;

  localparam logic [7:0] REG_EVENT_STATUS = 8'h00;
  localparam logic [7:0] REG_INTERRUPT_MASK = 8'h01;
  localparam logic [7:0] REG_PIN_STATE = 8'h11;
  localparam logic [7:0] REG_SHUTDOWN_MASK_CONFIG = 8'h17;
  localparam logic [7:0] REG_PORT_RESET_STROBE = 8'h1A;

  localparam int STB_RESET_ALL = 4;
  localparam int STB_INT_CLR0 = 6;
  localparam int STB_INT_CLR1 = 7;
  localparam int PIN_STANDALONE = 0;
  localparam int PIN_MIDSPAN = 1;
  localparam int PIN_GROUP_OFF = 2;

  localparam logic [2:0] ADDR_PREFIX = 3'h2;
  localparam logic [7:0] MASK_RST_HOST = 8'hFF;
  localparam logic [7:0] MASK_RST_STANDALONE = 8'h00;
  localparam logic [7:0] GROUP_RST = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // filter slots
  localparam int FLT_RESET = 0;
  localparam int FLT_PORT0 = 1;
  localparam int FLT_GROUP = 5;

  typedef enum logic [1:0] {PORT_IDLE, PORT_START, PORT_ON} ppc_port_e;
  typedef enum logic [3:0] {
    I2C_IDLE, I2C_ADDR, I2C_ACK_A, I2C_PTR, I2C_ACK_P,
    I2C_WDATA, I2C_ACK_W, I2C_RDATA, I2C_RACK, I2C_IGNORE
  } ppc_i2c_e;

  typedef struct packed {
    logic over_cut;
    logic sig_ok;
    logic unplug;
    logic volt_low;
  } ppc_port_in_s;
endpackage

/* verilog/ppc_port_control.sv */
// pin-level control of a quad power-sourcing controller with i2c slave
// Behaviour
// - chip reset low keeps ports off and restores all registers.
// - chip reset low pulses under 1us are ignored.
// - midspan input high selects midspan behaviour; defaults low.
// - interrupt output pulls low while any enabled event is pending.
// - writing bit 6 or 7 of the strobe register releases interrupt.
// - interrupt mask register bits suppress individual event sources.
// - interrupt level changes only between i2c transactions, except that a reset-all strobe write clears it at once.
// - slave address is 010 followed by the four address straps.
// - serial data is a separate sense input and open-drain drive.
// - port shutdown input turns port off like its strobe bit; filtered.
// - group shutdown turns off ports masked in config register; filtered.
// - standalone strap sets interrupt mask reset value; still writable later.
// - live standalone level reads at pin state bit 0.
// - fault timer counts while current exceeds overcurrent threshold.
// - timer expiry turns gate off and records timeout event.
// - power good set when port voltage falls below 2.4V.
// - power after valid signature; removed on unplug or fault.
// - faults during a transaction raise interrupt only after stop.
// - full reset at power-up or reset pin low; reset-all bit resets the rest but leaves the i2c slave running.
`timescale 1ns/100ps
module ppc_port_control #(
  parameter int FAULT_CYCLES = ppc_pkg::CUT_CYCLES
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic reset_n_pin,
  input wire logic midspan_sel,
  input wire logic standalone_sel,
  input wire logic addr_strap_0,
  input wire logic addr_strap_1,
  input wire logic addr_strap_2,
  input wire logic addr_strap_3,
  input wire logic port_off_n_1,
  input wire logic port_off_n_2,
  input wire logic port_off_n_3,
  input wire logic port_off_n_4,
  input wire logic group_off_n,
  input wire logic scl,
  input wire logic serial_data_sense,
  output logic serial_data_drive,
  output logic serial_data_drive_oe,
  output logic int_n,
  output logic int_n_oe,
  input wire logic [3:0] current_sense_in,
  input wire logic [3:0] port_voltage_in,
  input wire logic [3:0] signature_ok,
  input wire logic [3:0] unplugged,
  output logic [3:0] fet_drive,
  output logic [3:0] power_good,
  output logic midspan_mode
);
  localparam int NP = ppc_pkg::NPORT;
  localparam int NF = ppc_pkg::NFILT;
  localparam logic [ppc_pkg::FILT_W-1:0] FILT_MAX =
    ppc_pkg::FILT_W'(ppc_pkg::FILT_CYCLES - 1);
  localparam logic [ppc_pkg::CUT_W-1:0] CUT_MAX =
    ppc_pkg::CUT_W'(FAULT_CYCLES - 1);

  // two-flop synchronisers for every outside input but clock, srst and clk_en
  logic [NF-1:0] flt_raw, flt_m, flt_s;
  logic [3:0] misc_m, misc_s, strap_m, strap_s;
  ppc_pkg::ppc_port_in_s [NP-1:0] pin_m, pin_s, pin_raw;
  logic scl_d, sda_d;

  assign flt_raw = {group_off_n, port_off_n_4, port_off_n_3, port_off_n_2,
                    port_off_n_1, reset_n_pin};
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      pin_raw[i].over_cut = current_sense_in[i];
      pin_raw[i].sig_ok = signature_ok[i];
      pin_raw[i].unplug = unplugged[i];
      pin_raw[i].volt_low = port_voltage_in[i];
    end
  end

  always_ff @(posedge clock) begin
    if (clk_en) begin
      flt_m <= flt_raw;
      flt_s <= flt_m;
      misc_m <= {serial_data_sense, scl, standalone_sel, midspan_sel};
      misc_s <= misc_m;
      strap_m <= {addr_strap_3, addr_strap_2, addr_strap_1, addr_strap_0};
      strap_s <= strap_m;
      pin_m <= pin_raw;
      pin_s <= pin_m;
      scl_d <= misc_s[2];
      sda_d <= misc_s[3];
    end
  end

  wire mid_s = misc_s[0];
  wire stand_s = misc_s[1];
  wire scl_s = misc_s[2];
  wire sda_s = misc_s[3];

  // glitch filters: a low counts only after a full interval of holding
  logic [NF-1:0] flt_low;
  logic [ppc_pkg::FILT_W-1:0] flt_cnt [NF];
  genvar g;
  generate
    for (g = 0; g < NF; g++) begin : gen_filt
      always_ff @(posedge clock) begin
        if (srst) begin
          flt_cnt[g] <= '0;
          flt_low[g] <= 1'b0;
        end else if (clk_en) begin
          if (flt_s[g]) begin
            flt_cnt[g] <= '0;
            flt_low[g] <= 1'b0;
          end else if (flt_cnt[g] == FILT_MAX) begin
            flt_low[g] <= 1'b1;
          end else begin
            flt_cnt[g] <= flt_cnt[g] + 1'b1;
          end
        end
      end
      filt_hold_a: assert property (@(posedge clock) disable iff (srst)
        $rose(flt_low[g]) |-> $past(flt_cnt[g]) == FILT_MAX && !$past(flt_s[g]))
        else $error("filter released before full hold");
    end
  endgenerate

  // chip reset sources
  logic soft_rst;
  wire core_rst = srst | flt_low[ppc_pkg::FLT_RESET] | soft_rst;

  // i2c slave
  ppc_pkg::ppc_i2c_e i2c_st;
  logic [7:0] shift, tx, ptr;
  logic [3:0] bitcnt;
  logic rw, ack_ok, i2c_busy, wr_pulse;
  logic [7:0] wr_addr, wr_data;
  logic [7:0] interrupt_mask, shutdown_mask_config, ev_status;

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_c = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_c = scl_s & scl_d & ~sda_d & sda_s;
  wire [6:0] my_addr = {ppc_pkg::ADDR_PREFIX, strap_s};
  wire byte_done = bitcnt == ppc_pkg::BITS_PER_BYTE;

  function automatic logic [7:0] reg_read(
    input logic [7:0] a, input logic [7:0] msk, input logic [7:0] grp,
    input logic [7:0] ev, input logic st, input logic md, input logic go);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ppc_pkg::REG_EVENT_STATUS: v = ev;
      ppc_pkg::REG_INTERRUPT_MASK: v = msk;
      ppc_pkg::REG_SHUTDOWN_MASK_CONFIG: v = grp;
      ppc_pkg::REG_PIN_STATE: begin
        v[ppc_pkg::PIN_STANDALONE] = st;
        v[ppc_pkg::PIN_MIDSPAN] = md;
        v[ppc_pkg::PIN_GROUP_OFF] = go;
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  wire [7:0] rd_val = reg_read(ptr, interrupt_mask, shutdown_mask_config,
    ev_status, stand_s, mid_s, flt_low[ppc_pkg::FLT_GROUP]);

  always_ff @(posedge clock) begin
    if (srst || flt_low[ppc_pkg::FLT_RESET]) begin
      i2c_st <= ppc_pkg::I2C_IDLE;
      shift <= 8'h00;
      tx <= 8'h00;
      ptr <= 8'h00;
      bitcnt <= 4'h0;
      rw <= 1'b0;
      ack_ok <= 1'b0;
      i2c_busy <= 1'b0;
      serial_data_drive_oe <= 1'b0;
      wr_pulse <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else if (clk_en) begin
      wr_pulse <= 1'b0;
      if (start_c) begin
        i2c_st <= ppc_pkg::I2C_ADDR;
        bitcnt <= 4'h0;
        i2c_busy <= 1'b1;
        serial_data_drive_oe <= 1'b0;
      end else if (stop_c) begin
        i2c_st <= ppc_pkg::I2C_IDLE;
        i2c_busy <= 1'b0;
        serial_data_drive_oe <= 1'b0;
      end else if (scl_rise) begin
        case (i2c_st)
          ppc_pkg::I2C_ADDR, ppc_pkg::I2C_PTR, ppc_pkg::I2C_WDATA,
          ppc_pkg::I2C_RDATA: begin
            shift <= {shift[6:0], sda_s};
            bitcnt <= bitcnt + 1'b1;
          end
          ppc_pkg::I2C_RACK: ack_ok <= ~sda_s;
          default: ;
        endcase
      end else if (scl_fall) begin
        case (i2c_st)
          ppc_pkg::I2C_ADDR: if (byte_done) begin
            if (shift[7:1] == my_addr) begin
              rw <= shift[0];
              serial_data_drive_oe <= 1'b1;
              i2c_st <= ppc_pkg::I2C_ACK_A;
            end else begin
              i2c_st <= ppc_pkg::I2C_IGNORE;
            end
          end
          ppc_pkg::I2C_ACK_A: begin
            bitcnt <= 4'h0;
            if (rw) begin
              serial_data_drive_oe <= ~rd_val[7];
              tx <= {rd_val[6:0], 1'b0};
              i2c_st <= ppc_pkg::I2C_RDATA;
            end else begin
              serial_data_drive_oe <= 1'b0;
              i2c_st <= ppc_pkg::I2C_PTR;
            end
          end
          ppc_pkg::I2C_PTR: if (byte_done) begin
            ptr <= shift;
            serial_data_drive_oe <= 1'b1;
            i2c_st <= ppc_pkg::I2C_ACK_P;
          end
          ppc_pkg::I2C_WDATA: if (byte_done) begin
            wr_pulse <= 1'b1;
            wr_addr <= ptr;
            wr_data <= shift;
            serial_data_drive_oe <= 1'b1;
            i2c_st <= ppc_pkg::I2C_ACK_W;
          end
          ppc_pkg::I2C_ACK_P, ppc_pkg::I2C_ACK_W: begin
            bitcnt <= 4'h0;
            serial_data_drive_oe <= 1'b0;
            i2c_st <= ppc_pkg::I2C_WDATA;
          end
          ppc_pkg::I2C_RDATA: begin
            if (byte_done) begin
              serial_data_drive_oe <= 1'b0;
              i2c_st <= ppc_pkg::I2C_RACK;
            end else begin
              serial_data_drive_oe <= ~tx[7];
              tx <= {tx[6:0], 1'b0};
            end
          end
          ppc_pkg::I2C_RACK: begin
            bitcnt <= 4'h0;
            if (ack_ok) begin
              serial_data_drive_oe <= ~rd_val[7];
              tx <= {rd_val[6:0], 1'b0};
              i2c_st <= ppc_pkg::I2C_RDATA;
            end else begin
              i2c_st <= ppc_pkg::I2C_IGNORE;
            end
          end
          default: ;
        endcase
      end
    end
  end

  ack_addr_a: assert property (@(posedge clock) disable iff (srst)
    i2c_st == ppc_pkg::I2C_ADDR && scl_fall && byte_done && !start_c &&
    !stop_c && shift[7:1] != my_addr |=> !serial_data_drive_oe)
    else $error("acknowledged a foreign address");

  // serial data drive pin only ever pulls low
  always_ff @(posedge clock) begin
    serial_data_drive <= 1'b0;
    int_n <= 1'b0;
  end

  // register writes and strobes
  logic [3:0] port_strobe;
  logic int_clr;
  wire wr_strobe = wr_pulse && wr_addr == ppc_pkg::REG_PORT_RESET_STROBE;

  always_ff @(posedge clock) begin
    if (core_rst) begin
      // standalone strap picks the initial interrupt mask
      interrupt_mask <= stand_s ? ppc_pkg::MASK_RST_STANDALONE
                                : ppc_pkg::MASK_RST_HOST;
      shutdown_mask_config <= ppc_pkg::GROUP_RST;
      port_strobe <= 4'h0;
      int_clr <= 1'b0;
      soft_rst <= 1'b0;
    end else if (clk_en) begin
      port_strobe <= wr_strobe ? wr_data[3:0] : 4'h0;
      int_clr <= wr_strobe && (wr_data[ppc_pkg::STB_INT_CLR0] ||
                               wr_data[ppc_pkg::STB_INT_CLR1]);
      soft_rst <= wr_strobe && wr_data[ppc_pkg::STB_RESET_ALL];
      if (wr_pulse && wr_addr == ppc_pkg::REG_INTERRUPT_MASK)
        interrupt_mask <= wr_data;
      if (wr_pulse && wr_addr == ppc_pkg::REG_SHUTDOWN_MASK_CONFIG)
        shutdown_mask_config <= wr_data;
    end
  end

  always_ff @(posedge clock) begin
    if (core_rst) begin
      midspan_mode <= 1'b0;
    end else if (clk_en) begin
      midspan_mode <= mid_s;
    end
  end

  // per-port power and fault handling
  ppc_pkg::ppc_port_e port_st [NP];
  logic [ppc_pkg::CUT_W-1:0] cut_cnt [NP];
  logic [NP-1:0] kill, ev_cut, ev_start;

  generate
    for (g = 0; g < NP; g++) begin : gen_port
      assign kill[g] = flt_low[ppc_pkg::FLT_PORT0 + g] | port_strobe[g] |
        (flt_low[ppc_pkg::FLT_GROUP] & shutdown_mask_config[g]);
      wire expire = pin_s[g].over_cut && cut_cnt[g] == CUT_MAX;

      always_ff @(posedge clock) begin
        if (core_rst) begin
          port_st[g] <= ppc_pkg::PORT_IDLE;
          cut_cnt[g] <= '0;
          fet_drive[g] <= 1'b0;
          power_good[g] <= 1'b0;
          ev_cut[g] <= 1'b0;
          ev_start[g] <= 1'b0;
        end else if (clk_en) begin
          ev_cut[g] <= 1'b0;
          ev_start[g] <= 1'b0;
          if (!pin_s[g].over_cut || port_st[g] == ppc_pkg::PORT_IDLE)
            cut_cnt[g] <= '0;
          else if (!expire)
            cut_cnt[g] <= cut_cnt[g] + 1'b1;
          case (port_st[g])
            ppc_pkg::PORT_IDLE:
              if (!kill[g] && pin_s[g].sig_ok) begin
                port_st[g] <= ppc_pkg::PORT_START;
                fet_drive[g] <= 1'b1;
              end
            ppc_pkg::PORT_START, ppc_pkg::PORT_ON: begin
              if (kill[g] || expire || pin_s[g].unplug) begin
                port_st[g] <= ppc_pkg::PORT_IDLE;
                fet_drive[g] <= 1'b0;
                ev_cut[g] <= expire && port_st[g] == ppc_pkg::PORT_ON;
                ev_start[g] <= expire && port_st[g] == ppc_pkg::PORT_START;
              end else if (pin_s[g].volt_low) begin
                port_st[g] <= ppc_pkg::PORT_ON;
              end
            end
            default: port_st[g] <= ppc_pkg::PORT_IDLE;
          endcase
          power_good[g] <= pin_s[g].volt_low &&
            port_st[g] != ppc_pkg::PORT_IDLE;
        end
      end

      port_kill_a: assert property (@(posedge clock) disable iff (srst)
        clk_en && kill[g] && !core_rst |=> !fet_drive[g] &&
        port_st[g] == ppc_pkg::PORT_IDLE)
        else $error("port stayed powered under shutdown");
      fault_exp_a: assert property (@(posedge clock) disable iff (srst)
        clk_en && !core_rst && expire && port_st[g] != ppc_pkg::PORT_IDLE
        |=> !fet_drive[g] ##1 (ev_status[g] || ev_status[g + NP]))
        else $error("fault expiry did not turn port off");
      pg_level_a: assert property (@(posedge clock) disable iff (srst)
        power_good[g] |-> $past(pin_s[g].volt_low))
        else $error("power good without low port voltage");
      fet_reset_a: assert property (@(posedge clock) disable iff (srst)
        core_rst |=> !fet_drive[g] ##1 !fet_drive[g] || !core_rst)
        else $error("port powered during reset");
    end
  endgenerate

  // events, mask and interrupt pin
  wire [7:0] ev_set = {ev_start, ev_cut};
  wire pending = |(ev_status & interrupt_mask);

  always_ff @(posedge clock) begin
    if (core_rst) begin
      ev_status <= 8'h00;
      int_n_oe <= 1'b0;
    end else if (clk_en) begin
      // a new event in the clearing cycle survives
      ev_status <= (int_clr ? 8'h00 : ev_status) | ev_set;
      if (!i2c_busy)
        int_n_oe <= pending;
    end
  end

  int_hold_a: assert property (@(posedge clock) disable iff (core_rst)
    i2c_busy && $past(i2c_busy) |-> $stable(int_n_oe))
    else $error("interrupt changed during a transaction");
  int_mask_a: assert property (@(posedge clock) disable iff (core_rst)
    $rose(int_n_oe) |-> $past(pending) && !$past(i2c_busy))
    else $error("interrupt from masked event");
  int_clear_a: assert property (@(posedge clock) disable iff (core_rst)
    clk_en && int_clr && ev_set == 8'h00 |=> ev_status == 8'h00)
    else $error("events not cleared by strobe");
endmodule
